/* File: src/tli_defines.vh */
`ifndef TLI_DEFINES_VH
`define TLI_DEFINES_VH
// control register location and reset value
`define TLI_LINE_INTERFACE_CONTROL_ADDR      8'h7C
`define TLI_LINE_INTERFACE_CONTROL_RESET     8'h00
// control register field positions
`define TLI_BO_HI          7
`define TLI_BO_LO          5
`define TLI_GAIN_BIT       4
`define TLI_PATH_BIT       3
`define TLI_DEPTH_BIT      2
`define TLI_BYPASS_BIT     1
`define TLI_PWRDN_BIT      0
// build-out codes from this one upward are long-haul attenuations
`define TLI_BO_LONG_HAUL   3'h5
// oversampling ratio and the trimmed divide ratios
`define TLI_OVERSAMPLE     5'h10
`define TLI_DIV_FAST       5'h0F
`define TLI_DIV_SLOW       5'h11
// phase loaded on a detected line pulse
`define TLI_PULSE_PHASE    4'h4
// bit periods without a pulse before carrier loss
`define TLI_LOSS_BITS      8'hC0
// attenuator buffer depths
`define TLI_DEPTH_SHALLOW  8'h20
`define TLI_DEPTH_DEEP     8'h80
// margin from either buffer end that trips the divide adjust
`define TLI_TRIP_MARGIN    8'h04
`endif

/* File: src/tli_jitter_fifo.v */
`timescale 1ns/1ps
`default_nettype none
`include "tli_defines.vh"

module tli_jitter_fifo #(
  parameter DEPTH = 128,
  parameter AW    = 7
) (
  // clocking
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         ce,
  // control
  input  wire         shallow,
  input  wire         flush,
  // fill side
  input  wire         inValid,
  input  wire         inData,
  output wire         inReady,
  // drain side
  output wire         outValid,
  output wire         outData,
  input  wire         outReady,
  // fill level
  output reg  [7:0]   level
);

  reg  [DEPTH-1:0] mem;
  reg  [AW-1:0]    wrPtr;
  reg  [AW-1:0]    rdPtr;
  wire [7:0]       limit;
  wire             doWrite;
  wire             doRead;

  // depth selects how much of the array is in use
  assign limit    = shallow ? `TLI_DEPTH_SHALLOW : `TLI_DEPTH_DEEP;
  assign inReady  = (level < limit) && !flush;
  assign outValid = (level != 8'h00) && !flush;
  assign outData  = mem[rdPtr];
  assign doWrite  = ce && inValid && inReady;
  assign doRead   = ce && outValid && outReady;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem   <= {DEPTH{1'b0}};
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      level <= 8'h00;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wrPtr <= {AW{1'b0}};
        rdPtr <= {AW{1'b0}};
        level <= 8'h00;
      end
      else
      begin
        if (doWrite)
        begin
          mem[wrPtr] <= inData;
          wrPtr      <= wrPtr + 1'b1;
        end
        if (doRead)
          rdPtr <= rdPtr + 1'b1;
        if (doWrite && !doRead)
          level <= level + 8'h01;
        else if (doRead && !doWrite)
          level <= level - 8'h01;
      end
    end
  end

endmodule // tli_jitter_fifo
`default_nettype wire

/* File: src/tli_line_interface.v */
`timescale 1ns/1ps
`default_nettype none
`include "tli_defines.vh"

// Operation
// - one eight-bit control register configures receiver, transmitter and attenuator
// - three build-out bits pick transmit waveform; codes 5 to 7 are long-haul
// - depth bit clear gives 128-bit buffer, set gives 32-bit buffer
// - power-down bit set tri-states both transmit line outputs
// - sixteen-times oversampler recovers receive clock and data
// - with carrier present and the attenuator off the receive path, recovered clock output follows the line clock
// - no line pulses raises carrier loss; recovered clock then follows master clock
// - attenuator in receive path gives smoothed near half-duty recovered clock
// - near buffer limits divide by 15 or 17 and raise limit-trip flag, except near empty under carrier loss when the attenuator is not in the transmit path
module tli_line_interface #(
  parameter DEPTH = 128,
  parameter AW    = 7
) (
  // clocking; ce is the sixteen-times oversampling tick
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         ce,
  // master clock pin
  input  wire         mclk,
  // parallel control port
  input  wire [7:0]   regAddr,
  input  wire         regWrite,
  input  wire         regRead,
  input  wire [7:0]   regWrData,
  output reg  [7:0]   regRdData,
  // receive line pins
  input  wire         receive_line_pos,
  input  wire         receive_line_neg,
  // transmit line pins
  output reg          transmit_line_pos,
  output reg          transmit_line_neg,
  output wire         transmit_line_oe,
  // transmit waveform and receive gain controls
  output wire [2:0]   build_out_sel,
  output wire         build_out_long_haul,
  output wire         receive_gain_limit,
  // receive data to framer
  output wire         rxBit,
  output wire         rxValid,
  input  wire         rxReady,
  // transmit data from framer
  input  wire         txBit,
  input  wire         txValid,
  output wire         txReady,
  // status
  output wire         recovered_clock_out,
  output reg          carrier_loss_condition,
  output reg          attenuator_limit_trip
);

  reg  [7:0]  line_interface_control;
  reg  [1:0]  posSync, negSync, mclkSync;
  reg  [3:0]  phase, txCnt;
  reg  [7:0]  quietBits;
  reg  [4:0]  smoothCnt, smoothDiv;
  reg  [1:0]  bufCount;
  reg         pulseSeen, pulseLast, amiPolarity, bufBit0, bufBit1;
  wire        attenuator_path_select, attenuator_depth_select;
  wire        attenuator_bypass, transmitter_power_down;
  wire        jaRx, jaTx, linePulse, pulseRise, bitStrobe, smoothTick, txTick;
  wire        fifoInValid, fifoInData, fifoInReady, fifoOutValid, fifoOutData, fifoOutReady;
  wire [7:0]  fifoLevel, fifoLimit;
  wire        bufInValid, bufInData, bufInReady, txSendValid, txSendBit;

  // single control register feeds every section
  assign build_out_sel           = line_interface_control[`TLI_BO_HI:`TLI_BO_LO];
  assign receive_gain_limit      = line_interface_control[`TLI_GAIN_BIT];
  assign attenuator_path_select  = line_interface_control[`TLI_PATH_BIT];
  assign attenuator_depth_select = line_interface_control[`TLI_DEPTH_BIT];
  assign attenuator_bypass       = line_interface_control[`TLI_BYPASS_BIT];
  assign transmitter_power_down  = line_interface_control[`TLI_PWRDN_BIT];

  assign build_out_long_haul = (build_out_sel >= `TLI_BO_LONG_HAUL);

  assign jaRx = !attenuator_bypass && !attenuator_path_select;
  assign jaTx = !attenuator_bypass && attenuator_path_select;

  // register write and read-back, live immediately
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      line_interface_control <= `TLI_LINE_INTERFACE_CONTROL_RESET;
      regRdData              <= 8'h00;
    end
    else if (ce)
    begin
      if (regWrite && (regAddr == `TLI_LINE_INTERFACE_CONTROL_ADDR))
        line_interface_control <= regWrData;
      if (regRead)
        regRdData <= (regAddr == `TLI_LINE_INTERFACE_CONTROL_ADDR) ? line_interface_control : 8'h00;
    end
  end

  // line pins and master clock come from outside the clock domain
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      posSync  <= 2'h0;
      negSync  <= 2'h0;
      mclkSync <= 2'h0;
    end
    else if (ce)
    begin
      posSync  <= {posSync[0], receive_line_pos};
      negSync  <= {negSync[0], receive_line_neg};
      mclkSync <= {mclkSync[0], mclk};
    end
  end

  // either rail marks a bipolar mark
  assign linePulse = posSync[1] | negSync[1];
  assign pulseRise = linePulse && !pulseLast;
  assign bitStrobe = ce && (phase == 4'hF);

  // oversampled phase tracker; realigning on pulses stretches or shortens low phases
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pulseLast              <= 1'b0;
      phase                  <= 4'h0;
      pulseSeen              <= 1'b0;
      quietBits              <= 8'h00;
      carrier_loss_condition <= 1'b1;
    end
    else if (ce)
    begin
      pulseLast <= linePulse;
      if (pulseRise)
        phase <= `TLI_PULSE_PHASE;
      else
        phase <= phase + 4'h1;
      // a pulse in the same cycle as the bit strobe belongs to the next bit
      if (phase == 4'hF)
        pulseSeen <= pulseRise;
      else if (pulseRise)
        pulseSeen <= 1'b1;
      // carrier loss after a run of empty bit periods
      if (pulseRise)
      begin
        quietBits              <= 8'h00;
        carrier_loss_condition <= 1'b0;
      end
      else if (phase == 4'hF)
      begin
        if (quietBits >= `TLI_LOSS_BITS - 8'h01)
          carrier_loss_condition <= 1'b1;
        else
          quietBits <= quietBits + 8'h01;
      end
    end
  end

  // trimmed divider keeps the attenuator buffer from overrunning
  assign fifoLimit  = attenuator_depth_select ? `TLI_DEPTH_SHALLOW : `TLI_DEPTH_DEEP;
  assign smoothTick = ce && (smoothCnt == smoothDiv - 5'h01);

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      smoothCnt             <= 5'h00;
      smoothDiv             <= `TLI_OVERSAMPLE;
      attenuator_limit_trip <= 1'b0;
    end
    else if (ce)
    begin
      if (smoothCnt == smoothDiv - 5'h01)
      begin
        smoothCnt <= 5'h00;
        if (fifoLevel + `TLI_TRIP_MARGIN >= fifoLimit)
        begin
          smoothDiv             <= `TLI_DIV_FAST;
          attenuator_limit_trip <= 1'b1;
        end
        else if ((fifoLevel < `TLI_TRIP_MARGIN) && (jaTx || !carrier_loss_condition))
        begin
          smoothDiv             <= `TLI_DIV_SLOW;
          attenuator_limit_trip <= 1'b1;
        end
        else
        begin
          smoothDiv             <= `TLI_OVERSAMPLE;
          attenuator_limit_trip <= 1'b0;
        end
      end
      else
        smoothCnt <= smoothCnt + 5'h01;
    end
  end

  // path select picks receive or transmit feed; a disabled attenuator is held empty
  assign fifoInValid  = jaRx ? (phase == 4'hF) : (jaTx && txValid);
  assign fifoInData   = jaRx ? pulseSeen : txBit;
  assign fifoOutReady = smoothTick && (jaTx || bufInReady);

  tli_jitter_fifo #(.DEPTH (DEPTH), .AW (AW)) tli_jitter_fifo_inst (
    .clk      (clk),          .sys_rst  (sys_rst),
    .ce       (ce),           .shallow  (attenuator_depth_select),
    .flush    (!(jaRx || jaTx)),
    .inValid  (fifoInValid),  .inData   (fifoInData),  .inReady  (fifoInReady),
    .outValid (fifoOutValid), .outData  (fifoOutData), .outReady (fifoOutReady),
    .level    (fifoLevel)
  );

  // receive bits reach the framer through a two-entry buffer
  assign bufInValid = jaRx ? (smoothTick && fifoOutValid) : bitStrobe;
  assign bufInData  = jaRx ? fifoOutData : pulseSeen;
  assign bufInReady = (bufCount != 2'h2);
  assign rxValid    = (bufCount != 2'h0);
  assign rxBit      = bufBit0;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bufCount <= 2'h0;
      bufBit0  <= 1'b0;
      bufBit1  <= 1'b0;
    end
    else if (ce)
    begin
      if (rxValid && rxReady)
      begin
        bufBit0 <= (bufCount == 2'h2) ? bufBit1 : bufInData;
        if (!(bufInValid && bufInReady))
          bufCount <= bufCount - 2'h1;
      end
      else if (bufInValid && bufInReady)
      begin
        if (bufCount == 2'h0)
          bufBit0 <= bufInData;
        else
          bufBit1 <= bufInData;
        bufCount <= bufCount + 2'h1;
      end
    end
  end

  assign recovered_clock_out = carrier_loss_condition ? mclkSync[1] :
                               (jaRx ? (smoothCnt < (smoothDiv >> 1)) : phase[3]);

  // transmit bit timing: smoothed clock behind the attenuator, else a fixed /16
  assign txTick      = ce && (txCnt == 4'hF);
  assign txReady     = jaTx ? fifoInReady : txTick;
  assign txSendValid = jaTx ? (smoothTick && fifoOutValid) : (txTick && txValid);
  assign txSendBit   = jaTx ? fifoOutData : txBit;

  assign transmit_line_oe = !transmitter_power_down;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txCnt             <= 4'h0;
      amiPolarity       <= 1'b0;
      transmit_line_pos <= 1'b0;
      transmit_line_neg <= 1'b0;
    end
    else if (ce)
    begin
      txCnt <= txCnt + 4'h1;
      // a mark alternates rails; the rails hold their level until the next bit is sent or power-down clears them
      if (txSendValid)
      begin
        transmit_line_pos <= txSendBit && !amiPolarity && !transmitter_power_down;
        transmit_line_neg <= txSendBit && amiPolarity && !transmitter_power_down;
        if (txSendBit)
          amiPolarity <= !amiPolarity;
      end
      else if (transmitter_power_down)
      begin
        transmit_line_pos <= 1'b0;
        transmit_line_neg <= 1'b0;
      end
    end
  end

endmodule // tli_line_interface
`default_nettype wire

/* File: test/tli_line_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tli_line_chk (
  // clocking
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ce,
  // control port
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // line and status
  input wire logic       receive_line_pos,
  input wire logic       receive_line_neg,
  input wire logic       transmit_line_pos,
  input wire logic       transmit_line_neg,
  input wire logic       transmit_line_oe,
  input wire logic [2:0] build_out_sel,
  input wire logic       build_out_long_haul,
  input wire logic       receive_gain_limit,
  input wire logic       carrier_loss_condition
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] quiet;
  wire         wrHit = ce && regWrite && regAddr == 8'h7C;
  // ce ticks since last line mark, saturating
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) quiet <= 12'h000;
    else if (receive_line_pos || receive_line_neg) quiet <= 12'h000;
    else if (ce && quiet != 12'hFFF) quiet <= quiet + 12'h001;
  property p_wr_cfg;
    wrHit |=> build_out_sel == $past(regWrData[7:5]) && receive_gain_limit == $past(regWrData[4]);
  endproperty
  a_wr_cfg: assert property (p_wr_cfg) else $error("control write not applied");
  property p_long;
    build_out_long_haul == (build_out_sel >= 3'h5);
  endproperty
  a_long: assert property (p_long) else $error("long haul flag wrong");
  property p_cfg_hold;
    !$past(wrHit) |-> $stable(build_out_sel) && $stable(transmit_line_oe);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("control moved without write");
  property p_wr_oe;
    wrHit |=> transmit_line_oe == !$past(regWrData[0]);
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("output enable wrong");
  property p_pd_rails;
    !transmit_line_oe [*2] |-> !transmit_line_pos && !transmit_line_neg;
  endproperty
  a_pd_rails: assert property (p_pd_rails) else $error("rails active in power down");
  property p_rd_other;
    ce && regRead && regAddr != 8'h7C ##1 !regRead |-> ##1 regRdData == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");
  property p_rd_back;
    ce && regRead && regAddr == 8'h7C && !regWrite ##1 !regRead
      |-> ##1 regRdData[7:5] == build_out_sel && regRdData[0] == !transmit_line_oe;
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("readback differs");
  property p_rd_hold;
    $changed(regRdData) |-> $past(ce && regRead) || $past(ce && regRead, 2);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_loss_set;
    quiet == 12'hC80 |-> carrier_loss_condition;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("loss not raised");
  property p_loss_clr;
    $fell(carrier_loss_condition) |-> quiet < 12'h040;
  endproperty
  a_loss_clr: assert property (p_loss_clr) else $error("loss cleared without marks");
endmodule // tli_line_chk
bind tli_line_interface tli_line_chk tli_line_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
  .receive_line_pos(receive_line_pos), .receive_line_neg(receive_line_neg),
  .transmit_line_pos(transmit_line_pos), .transmit_line_neg(transmit_line_neg),
  .transmit_line_oe(transmit_line_oe), .build_out_sel(build_out_sel),
  .build_out_long_haul(build_out_long_haul), .receive_gain_limit(receive_gain_limit),
  .carrier_loss_condition(carrier_loss_condition)
);
`default_nettype wire

/* File: test/tli_line_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tli_line_interface_tb;
  logic       clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, mclk = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
  logic       regWrite = 1'b0, regRead = 1'b0, rxReady = 1'b0;
  logic       txBit = 1'b0, txValid = 1'b0, carrierOn = 1'b0, slowLine = 1'b0;
  wire  [7:0] regRdData;
  wire  [2:0] build_out_sel;
  wire        linePos, lineNeg, txPos, txNeg, txOe, longHaul, gain;
  wire        rxBit, rxValid, txReady, rclk, loss, trip;
  int         err_count = 0, checked = 0, cycles = 0;
  int         rcRise, posRise, negRise, pops, ones, tripSeen, hi, acc;
  logic       rcLast, posLast, negLast;
  // data byte and long-haul flag per row
  logic [8:0] rows [0:7] = '{9'h000, 9'h062, 9'h084, 9'h0B6, 9'h108, 9'h14B, 9'h1BD, 9'h1CF};
  always #4 clk = ~clk;
  always #324 mclk = ~mclk;
  tli_line_model tli_line_model_inst (.clk(clk), .sys_rst(sys_rst), .carrierOn(carrierOn),
    .slowLine(slowLine), .linePos(linePos), .lineNeg(lineNeg));
  tli_line_interface tli_line_interface_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .mclk(mclk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .receive_line_pos(linePos),
    .receive_line_neg(lineNeg), .transmit_line_pos(txPos), .transmit_line_neg(txNeg),
    .transmit_line_oe(txOe), .build_out_sel(build_out_sel), .build_out_long_haul(longHaul),
    .receive_gain_limit(gain), .rxBit(rxBit), .rxValid(rxValid), .rxReady(rxReady),
    .txBit(txBit), .txValid(txValid), .txReady(txReady), .recovered_clock_out(rclk),
    .carrier_loss_condition(loss), .attenuator_limit_trip(trip));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("ERROR %0t run timed out", $time);
      close_out;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    tick(1);
    regWrite = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    regRead = 1'b1;
    tick(1);
    regRead = 1'b0;
    tick(2);
    check(regRdData, exp, "read data");
  endtask
  task automatic wait_loss(input logic lvl, input int lim);
    for (int k = 0; k < lim && loss !== lvl; k++) tick(1);
    check(loss, lvl, "carrier loss");
  endtask
  // edges, pops and high time seen over n cycles
  task automatic watch(input int n);
    {rcRise, posRise, negRise, pops, ones, tripSeen, hi, acc} = '0;
    repeat (n)
    begin
      @(negedge clk);
      rcRise += int'(rclk && !rcLast);
      posRise += int'(txPos && !posLast);
      negRise += int'(txNeg && !negLast);
      pops += int'(rxValid && rxReady);
      ones += int'(rxValid && rxReady && rxBit);
      tripSeen += int'(trip);
      hi += int'(rclk);
      acc += int'(txValid && txReady);
      {rcLast, posLast, negLast} = {rclk, txPos, txNeg};
    end
    tick(1);
  endtask
  initial
  begin
    tick(8);
    sys_rst = 1'b0;
    check(loss, 1'b1, "loss at reset");
    check(txOe, 1'b1, "enable at reset");
    rd(8'h7C, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h7C, rows[i][8:1]);
      check(build_out_sel, rows[i][8:6], "build out");
      check(longHaul, rows[i][0], "long haul");
      check(gain, rows[i][5], "gain limit");
      check(txOe, !rows[i][1], "output enable");
      rd(8'h7C, rows[i][8:1]);
    end
    ce = 1'b0;
    wr(8'h7C, 8'h00);
    check(build_out_sel, 3'h7, "write frozen by clock enable");
    ce = 1'b1;
    wr(8'h7D, 8'h00);
    rd(8'h7C, 8'hE7);
    rd(8'h7E, 8'h00);
    $display("test register done");
    wr(8'h7C, 8'h02);
    carrierOn = 1'b1;
    rxReady = 1'b1;
    wait_loss(1'b0, 400);
    watch(320);
    check(rcRise >= 18 && rcRise <= 22, 1'b1, "line clock");
    check(pops > 0 && ones == pops, 1'b1, "receive marks");
    rxReady = 1'b0;
    watch(400);
    check(rxValid, 1'b1, "held while stalled");
    rxReady = 1'b1;
    watch(160);
    check(pops > 0 && ones == pops, 1'b1, "receive after stall");
    $display("test receive done");
    wr(8'h7C, 8'h04);
    slowLine = 1'b1;
    watch(3000);
    check(tripSeen > 0, 1'b1, "limit trip");
    check(hi * 20 >= 21000 && hi * 20 <= 39000, 1'b1, "smoothed duty");
    carrierOn = 1'b0;
    wait_loss(1'b1, 3400);
    watch(320);
    check(rcRise >= 2 && rcRise <= 6, 1'b1, "master clock");
    $display("test attenuator and loss done");
    wr(8'h7C, 8'h02);
    txBit = 1'b1;
    txValid = 1'b1;
    watch(320);
    check(posRise >= 8 && negRise >= 8, 1'b1, "alternate marks");
    wr(8'h7C, 8'h0C);
    watch(96);
    check(acc >= 20 && acc <= 48, 1'b1, "shallow attenuator fill");
    check(posRise >= 2 && negRise >= 2, 1'b1, "marks through attenuator");
    check(tripSeen > 0, 1'b1, "transmit limit trip");
    wr(8'h7C, 8'h08);
    watch(96);
    check(acc >= 90, 1'b1, "deep attenuator fill");
    wr(8'h7C, 8'h03);
    tick(2);
    check({txOe, txPos, txNeg}, 3'b000, "power down");
    $display("test transmit done");
    close_out;
  end
endmodule // tli_line_interface_tb
`default_nettype wire

/* File: test/tli_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tli_line_model (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  // line behaviour
  input wire logic carrierOn,
  input wire logic slowLine,
  // bipolar rails
  output logic     linePos,
  output logic     lineNeg
);
  logic [4:0] phase;
  logic       polarity;
  // slow line stretches a bit to 17 ticks
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      phase <= 5'h00;
      polarity <= 1'b0;
    end
    else if (phase >= (slowLine ? 5'h10 : 5'h0F))
    begin
      phase <= 5'h00;
      polarity <= ~polarity;
    end
    else phase <= phase + 5'h01;
  assign linePos = carrierOn && phase < 5'h08 && !polarity;
  assign lineNeg = carrierOn && phase < 5'h08 && polarity;
endmodule // tli_line_model
`default_nettype wire
